// ---- core/cafd_alu.sv ----
`timescale 1ns/1ps
// Combinational 8-bit ALU with flag generation.
module cafd_alu (
   input wire logic [3:0] op,
   input wire logic [7:0] a_w,
   input wire logic [7:0] b_f,
   input wire logic c_in,
   output logic [7:0] res,
   output logic c_out,
   output logic nib_out,
   output logic z_out,
   output logic wrap_out,
   output logic upd_cdc,
   output logic upd_wrap,
   output logic upd_z
);
   logic [8:0] lo_sum;
   logic [4:0] nib_sum;
   logic [7:0] opb;
   logic cin_eff;
   logic is_arith;
   logic c7_in;

   // Subtraction adds the inverted W operand, so carries read as active-low borrows.
   assign is_arith = (op == 4'(cafd_pkg::CAFD_OP_ADD)) || (op == 4'(cafd_pkg::CAFD_OP_ADDC))
      || (op == 4'(cafd_pkg::CAFD_OP_SUB)) || (op == 4'(cafd_pkg::CAFD_OP_SUBB));
   assign opb = ((op == 4'(cafd_pkg::CAFD_OP_SUB)) || (op == 4'(cafd_pkg::CAFD_OP_SUBB)))
      ? ~a_w : a_w;
   assign cin_eff = (op == 4'(cafd_pkg::CAFD_OP_SUB)) ? 1'b1 :
      ((op == 4'(cafd_pkg::CAFD_OP_ADDC)) || (op == 4'(cafd_pkg::CAFD_OP_SUBB))) ? c_in : 1'b0;
   assign lo_sum = {1'b0, b_f} + {1'b0, opb} + {8'h00, cin_eff};
   assign nib_sum = {1'b0, b_f[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin_eff};
   assign c7_in = b_f[7] ^ opb[7] ^ lo_sum[7];

   // Result selection and flag outputs.
   always_comb begin
      res = b_f;
      c_out = c_in;
      unique case (op)
         4'(cafd_pkg::CAFD_OP_ADD), 4'(cafd_pkg::CAFD_OP_ADDC),
         4'(cafd_pkg::CAFD_OP_SUB), 4'(cafd_pkg::CAFD_OP_SUBB): begin
            res = lo_sum[7:0];
            c_out = lo_sum[8];
         end
         4'(cafd_pkg::CAFD_OP_AND): res = a_w & b_f;
         4'(cafd_pkg::CAFD_OP_IOR): res = a_w | b_f;
         4'(cafd_pkg::CAFD_OP_XOR): res = a_w ^ b_f;
         4'(cafd_pkg::CAFD_OP_COM): res = ~b_f;
         4'(cafd_pkg::CAFD_OP_RLC): begin
            res = {b_f[6:0], c_in};
            c_out = b_f[7];
         end
         4'(cafd_pkg::CAFD_OP_RRC): begin
            res = {c_in, b_f[7:1]};
            c_out = b_f[0];
         end
         default: res = b_f;
      endcase
   end

   assign nib_out = nib_sum[4];
   assign wrap_out = c7_in ^ lo_sum[8];
   assign z_out = (res == 8'h00);
   assign upd_cdc = is_arith || (op == 4'(cafd_pkg::CAFD_OP_RLC))
      || (op == 4'(cafd_pkg::CAFD_OP_RRC));
   assign upd_wrap = is_arith;
   assign upd_z = is_arith || (op == 4'(cafd_pkg::CAFD_OP_AND))
      || (op == 4'(cafd_pkg::CAFD_OP_IOR)) || (op == 4'(cafd_pkg::CAFD_OP_XOR))
      || (op == 4'(cafd_pkg::CAFD_OP_COM));
endmodule

// ---- core/cafd_core.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Fetch full 16-bit word per cycle, separate bus.
// - Two-stage pipeline, fetch overlaps execute.
// - Branches and table moves take extra cycle.
// - Program counter spans 64K words.
// - Internal, external or combined fetch modes.
// - Combined mode disables code protection.
// - Special registers readable/writable in data space.
// - File-to-file moves bypass working register.
// - ALU combines working register and file.
// - Unsigned 8x8 multiply in one cycle.
// - Add, subtract, shift, logic; two's complement.
// - Operations update carry, nibble, zero, wrap flags.
// - Subtract carries are active-low borrows.
// - Signed overflow beyond 127 or -128.
// - Overflow from bit-7 carries only.
// - Product into pair; flags untouched.
// - Multiply operands are unsigned.
module cafd_core (
   input wire logic CLK,
   input wire logic RST_N,
   // Program memory bus.
   output logic [15:0] PM_ADDR,
   input wire logic [15:0] PM_DATA,
   output logic PM_EXT_SEL,
   // Decoded execute-stage controls.
   input wire logic [3:0] EX_OP,
   input wire logic EX_DEST_W,
   input wire logic EX_MULTI,
   input wire logic EX_BRANCH,
   input wire logic [15:0] EX_TARGET,
   input wire logic [1:0] EXEC_MODE,
   input wire logic PROTECT_REQ,
   // Data memory bus.
   input wire logic [7:0] DM_RDATA,
   input wire logic [7:0] DM_SRC_DATA,
   output logic [7:0] DM_WDATA,
   output logic DM_WE,
   // Special-register access in data space.
   input wire logic [2:0] SFR_SEL,
   input wire logic SFR_WE,
   input wire logic [7:0] SFR_WDATA,
   output logic [7:0] SFR_RDATA,
   // State outputs.
   output logic [15:0] INSN_EX,
   output logic [7:0] WORK_REG,
   output logic [7:0] ALU_FLAGS,
   output logic [15:0] PRODUCT_PAIR,
   output logic PROTECT_ACTIVE,
   output logic STALL
);
   logic [15:0] pc_q, pc_d;
   logic [15:0] ir_q, ir_d;
   logic [7:0] working_register_q, working_register_d;
   logic [7:0] alu_flag_register_q, alu_flag_register_d;
   logic [15:0] product_pair_q, product_pair_d;
   logic [1:0] stall_cnt_q, stall_cnt_d;
   logic [7:0] alu_res;
   logic c_out, nib_out, z_out, wrap_out, upd_cdc, upd_wrap, upd_z;
   logic is_mul, is_movff, is_pass, is_multi, stalling, exec_ok;
   logic sfr_pc_lo, sfr_pc_hi, sfr_w, sfr_flag, sfr_prl, sfr_prh;
   logic wr_pc_lo, wr_pc_hi, wr_w, wr_flag, wr_prl, wr_prh;
   logic [7:0] flags_alu;
   logic [15:0] mul_res;

   cafd_alu u_alu (
      .op(EX_OP),
      .a_w(working_register_q),
      .b_f(DM_RDATA),
      .c_in(alu_flag_register_q[cafd_pkg::FLAG_C_POS]),
      .res(alu_res),
      .c_out(c_out),
      .nib_out(nib_out),
      .z_out(z_out),
      .wrap_out(wrap_out),
      .upd_cdc(upd_cdc),
      .upd_wrap(upd_wrap),
      .upd_z(upd_z)
   );

   // Operation decode and stall control.
   assign is_mul = (EX_OP == 4'(cafd_pkg::CAFD_OP_MUL));
   assign is_movff = (EX_OP == 4'(cafd_pkg::CAFD_OP_MOVFF));
   assign is_pass = (EX_OP == 4'(cafd_pkg::CAFD_OP_PASS));
   assign is_multi = (EX_MULTI || EX_BRANCH) && (stall_cnt_q == 2'h0);
   assign stalling = is_multi || (stall_cnt_q != 2'h0);
   assign STALL = stalling;
   // An instruction acts in its first cycle only; the bubble cycle is inert.
   assign exec_ok = !stalling || is_multi;

   // Unsigned multiply, completes in the execute cycle.
   assign mul_res = {8'h00, working_register_q} * {8'h00, DM_RDATA};

   // Special-register decode in data space.
   assign sfr_pc_lo = (SFR_SEL == cafd_pkg::SFR_PC_LO);
   assign sfr_pc_hi = (SFR_SEL == cafd_pkg::SFR_PC_HI);
   assign sfr_w = (SFR_SEL == cafd_pkg::SFR_WORK);
   assign sfr_flag = (SFR_SEL == cafd_pkg::SFR_FLAGS);
   assign sfr_prl = (SFR_SEL == cafd_pkg::SFR_PROD_LO);
   assign sfr_prh = (SFR_SEL == cafd_pkg::SFR_PROD_HI);

   // Write strobes; a data-space write overrides the ALU update of the same register.
   assign wr_pc_lo = SFR_WE && sfr_pc_lo;
   assign wr_pc_hi = SFR_WE && sfr_pc_hi;
   assign wr_w = SFR_WE && sfr_w;
   assign wr_flag = SFR_WE && sfr_flag;
   assign wr_prl = SFR_WE && sfr_prl;
   assign wr_prh = SFR_WE && sfr_prh;
   assign SFR_RDATA = sfr_pc_lo ? pc_q[7:0] : sfr_pc_hi ? pc_q[15:8] :
      sfr_w ? working_register_q : sfr_flag ? alu_flag_register_q :
      sfr_prl ? product_pair_q[7:0] : sfr_prh ? product_pair_q[15:8] : 8'h00;

   // Flag merge: only the bits the operation touches change.
   always_comb begin
      flags_alu = alu_flag_register_q;
      if (upd_cdc) begin
         flags_alu[cafd_pkg::FLAG_C_POS] = c_out;
      end
      if (upd_wrap) begin
         flags_alu[cafd_pkg::FLAG_NIB_POS] = nib_out;
         flags_alu[cafd_pkg::FLAG_WRAP_POS] = wrap_out;
      end
      if (upd_z) begin
         flags_alu[cafd_pkg::FLAG_Z_POS] = z_out;
      end
   end

   // Next-state logic for the pipeline and architectural registers.
   always_comb begin
      pc_d = pc_q + 16'h0001;
      ir_d = PM_DATA;
      stall_cnt_d = (stall_cnt_q != 2'h0) ? stall_cnt_q - 2'h1 : 2'h0;
      working_register_d = working_register_q;
      alu_flag_register_d = alu_flag_register_q;
      product_pair_d = product_pair_q;
      if (is_multi) begin
         stall_cnt_d = cafd_pkg::MULTI_EXTRA;
         ir_d = cafd_pkg::INSN_NOP;
         if (EX_BRANCH) begin
            pc_d = EX_TARGET;
         end
      end else if (stalling) begin
         ir_d = PM_DATA;
      end
      if (exec_ok) begin
         if (is_mul) begin
            product_pair_d = mul_res;
         end else if (!is_movff && !is_pass) begin
            alu_flag_register_d = flags_alu;
            if (EX_DEST_W) begin
               working_register_d = alu_res;
            end
         end
      end
      if (wr_pc_lo) pc_d = {pc_q[15:8], SFR_WDATA};
      if (wr_pc_hi) pc_d = {SFR_WDATA, pc_q[7:0]};
      if (wr_w) working_register_d = SFR_WDATA;
      if (wr_flag) alu_flag_register_d = SFR_WDATA;
      if (wr_prl) product_pair_d = {product_pair_q[15:8], SFR_WDATA};
      if (wr_prh) product_pair_d = {SFR_WDATA, product_pair_q[7:0]};
   end

   // Data-memory write: file-to-file moves skip the working register.
   assign DM_WDATA = is_movff ? DM_SRC_DATA : alu_res;
   assign DM_WE = exec_ok && !is_mul && !is_pass && (is_movff || !EX_DEST_W);

   // Mode decode: external fetch and protection.
   assign PM_EXT_SEL = (EXEC_MODE == 2'(cafd_pkg::CAFD_MODE_MPU)) ||
      ((EXEC_MODE == 2'(cafd_pkg::CAFD_MODE_EXT)) && (pc_q >= cafd_pkg::EXT_BASE));
   assign PROTECT_ACTIVE = ((EXEC_MODE == 2'(cafd_pkg::CAFD_MODE_PROT)) ||
      ((EXEC_MODE == 2'(cafd_pkg::CAFD_MODE_MCU)) && PROTECT_REQ));

   // Program counter, the fetch address of the next word.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pc_q <= cafd_pkg::PC_RST;
      end else begin
         pc_q <= pc_d;
      end
   end

   // Instruction register, the execute stage of the pipeline.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ir_q <= cafd_pkg::INSN_NOP;
      end else begin
         ir_q <= ir_d;
      end
   end

   // Bubble counter for multi-cycle instructions.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         stall_cnt_q <= 2'h0;
      end else begin
         stall_cnt_q <= stall_cnt_d;
      end
   end

   // Working register.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         working_register_q <= cafd_pkg::WORK_RST;
      end else begin
         working_register_q <= working_register_d;
      end
   end

   // ALU flag register.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         alu_flag_register_q <= cafd_pkg::FLAGS_RST;
      end else begin
         alu_flag_register_q <= alu_flag_register_d;
      end
   end

   // Product pair written by the multiplier.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         product_pair_q <= cafd_pkg::PROD_RST;
      end else begin
         product_pair_q <= product_pair_d;
      end
   end

   assign PM_ADDR = pc_q;
   assign INSN_EX = ir_q;
   assign WORK_REG = working_register_q;
   assign ALU_FLAGS = alu_flag_register_q;
   assign PRODUCT_PAIR = product_pair_q;
endmodule

// ---- core/cafd_pkg.sv ----
package cafd_pkg;
   // Data and instruction widths.
   localparam int DATA_W = 8;
   localparam int INSN_W = 16;
   localparam int PC_W = 16;
   localparam int PROD_W = 16;
   // Flag bit positions inside the ALU flag register.
   localparam int FLAG_C_POS = 0;
   localparam int FLAG_NIB_POS = 1;
   localparam int FLAG_Z_POS = 2;
   localparam int FLAG_WRAP_POS = 3;
   // Reset values.
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [7:0] WORK_RST = 8'h00;
   localparam logic [15:0] PC_RST = 16'h0000;
   localparam logic [15:0] PROD_RST = 16'h0000;
   localparam logic [15:0] INSN_NOP = 16'h0000;
   // Stall cycles added by a branch or a table transfer.
   localparam logic [1:0] MULTI_EXTRA = 2'h1;
   // Special-register select codes in data space.
   localparam logic [2:0] SFR_PC_LO = 3'h0;
   localparam logic [2:0] SFR_PC_HI = 3'h1;
   localparam logic [2:0] SFR_WORK = 3'h2;
   localparam logic [2:0] SFR_FLAGS = 3'h3;
   localparam logic [2:0] SFR_PROD_LO = 3'h4;
   localparam logic [2:0] SFR_PROD_HI = 3'h5;
   // First program address served by external memory in the combined mode.
   localparam logic [15:0] EXT_BASE = 16'h2000;

   // ALU operation select.
   typedef enum logic [3:0] {
      CAFD_OP_PASS = 4'b0000,
      CAFD_OP_ADD = 4'b0001,
      CAFD_OP_ADDC = 4'b0010,
      CAFD_OP_SUB = 4'b0011,
      CAFD_OP_SUBB = 4'b0100,
      CAFD_OP_AND = 4'b0101,
      CAFD_OP_IOR = 4'b0110,
      CAFD_OP_XOR = 4'b0111,
      CAFD_OP_RLC = 4'b1000,
      CAFD_OP_RRC = 4'b1001,
      CAFD_OP_MUL = 4'b1010,
      CAFD_OP_MOVFF = 4'b1011,
      CAFD_OP_COM = 4'b1100
   } cafd_op_t;

   // Execution modes.
   typedef enum logic [1:0] {
      CAFD_MODE_MCU = 2'b00,
      CAFD_MODE_PROT = 2'b01,
      CAFD_MODE_EXT = 2'b10,
      CAFD_MODE_MPU = 2'b11
   } cafd_mode_t;
endpackage

// ---- tb/cafd_core_checker.sv ----
`timescale 1ns/1ps
// Watches the core ports for ALU, multiplier, fetch and mode behaviour.
module cafd_core_checker (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [3:0] EX_OP,
   input wire logic EX_DEST_W,
   input wire logic EX_BRANCH,
   input wire logic [15:0] EX_TARGET,
   input wire logic [15:0] PM_DATA,
   input wire logic [7:0] DM_RDATA,
   input wire logic SFR_WE,
   input wire logic [1:0] EXEC_MODE,
   input wire logic PROTECT_REQ,
   input wire logic [15:0] PM_ADDR,
   input wire logic [15:0] INSN_EX,
   input wire logic [7:0] WORK_REG,
   input wire logic [7:0] ALU_FLAGS,
   input wire logic [15:0] PRODUCT_PAIR,
   input wire logic PROTECT_ACTIVE,
   input wire logic STALL
);
   // Reference sums; subtraction is the file plus the inverted working register plus one.
   wire [8:0] sum = {1'b0, WORK_REG} + {1'b0, DM_RDATA};
   wire [8:0] dif = {1'b0, DM_RDATA} + {1'b0, ~WORK_REG} + 9'h001;
   wire [4:0] nib = {1'b0, WORK_REG[3:0]} + {1'b0, DM_RDATA[3:0]};
   wire [4:0] dnib = {1'b0, DM_RDATA[3:0]} + {1'b0, ~WORK_REG[3:0]} + 5'h01;
   wire ovf = WORK_REG[7] == DM_RDATA[7] && sum[7] != WORK_REG[7];
   wire calm = !STALL && !SFR_WE;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   // A branch leaves an empty instruction slot with the stall still up.
   sequence s_bubble;
      INSN_EX == 16'h0000 && STALL;
   endsequence

   a_mul_product: assert property (calm && EX_OP == 4'hA |=>
      PRODUCT_PAIR == 16'($past(WORK_REG)) * 16'($past(DM_RDATA))) else $error("product wrong");
   a_mul_flags: assert property (calm && EX_OP == 4'hA |=>
      $stable(ALU_FLAGS)) else $error("multiply touched flags");
   a_add_sum: assert property (calm && EX_OP == 4'h1 && EX_DEST_W |=>
      WORK_REG == $past(sum[7:0])) else $error("sum wrong");
   a_add_flags: assert property (calm && EX_OP == 4'h1 |=>
      ALU_FLAGS[2:0] == $past({sum[7:0] == 8'h00, nib[4], sum[8]})) else $error("add flags");
   a_add_ovf: assert property (calm && EX_OP == 4'h1 |=>
      ALU_FLAGS[3] == $past(ovf)) else $error("overflow wrong");
   a_sub_borrow: assert property (calm && EX_OP == 4'h3 |=>
      ALU_FLAGS[1:0] == $past({dnib[4], dif[8]})) else $error("borrow wrong");
   a_branch_bubble: assert property ($rose(STALL) && EX_BRANCH && !SFR_WE |=>
      s_bubble ##0 PM_ADDR == $past(EX_TARGET)) else $error("branch wrong");
   a_fetch_word: assert property (!STALL |=> INSN_EX == $past(PM_DATA))
      else $error("fetch wrong");
   a_protect_mode: assert property (PROTECT_ACTIVE ==
      (EXEC_MODE == 2'h1 || (EXEC_MODE == 2'h0 && PROTECT_REQ))) else $error("protect wrong");
endmodule

bind cafd_core cafd_core_checker u_chk (
   .CLK(CLK),
   .RST_N(RST_N),
   .EX_OP(EX_OP),
   .EX_DEST_W(EX_DEST_W),
   .EX_BRANCH(EX_BRANCH),
   .EX_TARGET(EX_TARGET),
   .PM_DATA(PM_DATA),
   .DM_RDATA(DM_RDATA),
   .SFR_WE(SFR_WE),
   .EXEC_MODE(EXEC_MODE),
   .PROTECT_REQ(PROTECT_REQ),
   .PM_ADDR(PM_ADDR),
   .INSN_EX(INSN_EX),
   .WORK_REG(WORK_REG),
   .ALU_FLAGS(ALU_FLAGS),
   .PRODUCT_PAIR(PRODUCT_PAIR),
   .PROTECT_ACTIVE(PROTECT_ACTIVE),
   .STALL(STALL)
);

// ---- tb/cafd_core_tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the core datapath.
module cafd_core_tb;
   logic CLK = 1'b0;
   logic RST_N = 1'b0;
   logic EX_DEST_W, EX_MULTI, EX_BRANCH, PROTECT_REQ, SFR_WE, PM_EXT_SEL, DM_WE;
   logic PROTECT_ACTIVE, STALL;
   logic [1:0] EXEC_MODE;
   logic [2:0] SFR_SEL;
   logic [3:0] EX_OP;
   logic [7:0] DM_RDATA, DM_SRC_DATA, SFR_WDATA, DM_WDATA, SFR_RDATA, WORK_REG, ALU_FLAGS;
   logic [15:0] PM_DATA, EX_TARGET, PM_ADDR, INSN_EX, PRODUCT_PAIR, e;
   logic [31:0] seed = 32'hB5FD;
   logic [7:0] w, f, fl;
   logic [3:0] op;
   logic dst;
   int n_errors = 0;
   int checked = 0;
   int cycles = 0;

   cafd_core dut (
      .CLK(CLK),
      .RST_N(RST_N),
      .PM_ADDR(PM_ADDR),
      .PM_DATA(PM_DATA),
      .PM_EXT_SEL(PM_EXT_SEL),
      .EX_OP(EX_OP),
      .EX_DEST_W(EX_DEST_W),
      .EX_MULTI(EX_MULTI),
      .EX_BRANCH(EX_BRANCH),
      .EX_TARGET(EX_TARGET),
      .EXEC_MODE(EXEC_MODE),
      .PROTECT_REQ(PROTECT_REQ),
      .DM_RDATA(DM_RDATA),
      .DM_SRC_DATA(DM_SRC_DATA),
      .DM_WDATA(DM_WDATA),
      .DM_WE(DM_WE),
      .SFR_SEL(SFR_SEL),
      .SFR_WE(SFR_WE),
      .SFR_WDATA(SFR_WDATA),
      .SFR_RDATA(SFR_RDATA),
      .INSN_EX(INSN_EX),
      .WORK_REG(WORK_REG),
      .ALU_FLAGS(ALU_FLAGS),
      .PRODUCT_PAIR(PRODUCT_PAIR),
      .PROTECT_ACTIVE(PROTECT_ACTIVE),
      .STALL(STALL)
   );

   // Clock at 25 MHz.
   always #20 CLK = ~CLK;

   // Cuts a hung run short.
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 2000) begin
         n_errors++;
         summarize();
      end
   end

   // Next value of the xorshift sequence.
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Expected flag register and result of one ALU operation.
   function automatic logic [15:0] model(logic [3:0] o, logic [7:0] a, d, logic [7:0] g);
      logic [7:0] b;
      logic [8:0] s;
      logic [4:0] h;
      logic c;
      b = (o == 4'h3 || o == 4'h4) ? ~a : a;
      c = (o == 4'h3) | ((o == 4'h2 || o == 4'h4) & g[0]);
      s = {1'b0, d} + {1'b0, b} + {8'h00, c};
      h = {1'b0, d[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
      case (o)
         4'h1, 4'h2, 4'h3, 4'h4: begin
            g[3:0] = {d[7] == b[7] && s[7] != d[7], s[7:0] == 8'h00, h[4], s[8]};
            return {g, s[7:0]};
         end
         4'h5, 4'h6, 4'h7, 4'hC: begin
            s[7:0] = o == 4'hC ? ~d : o == 4'h5 ? a & d : o == 4'h6 ? a | d : a ^ d;
            g[2] = s[7:0] == 8'h00;
            return {g, s[7:0]};
         end
         4'h8: return {g[7:1], d[7], d[6:0], g[0]};
         4'h9: return {g[7:1], d[0], g[0], d[7:1]};
         default: return {g, d};
      endcase
   endfunction

   // Compares one value and counts it.
   task automatic chk(logic [15:0] seen, logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Applies one cycle of inputs at the falling edge.
   task automatic drive(logic [3:0] o, logic [2:0] sel, logic we, logic [7:0] wd, d);
      @(negedge CLK);
      EX_OP = o;
      EX_DEST_W = (o != 4'hB) && dst;
      SFR_SEL = sel;
      SFR_WE = we;
      SFR_WDATA = wd;
      DM_RDATA = d;
      PM_DATA = 16'(rnd());
      DM_SRC_DATA = 8'(rnd());
      EXEC_MODE = 2'(rnd());
      PROTECT_REQ = 1'(rnd());
      #1;
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic summarize();
      $display("checked=%0d n_errors=%0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Reset, then ALU sweep, file move, branch and table transfer, and modes.
   initial begin
      {EX_OP, EX_DEST_W, EX_MULTI, EX_BRANCH, EX_TARGET, EXEC_MODE, PROTECT_REQ} = '0;
      {PM_DATA, DM_RDATA, DM_SRC_DATA, SFR_SEL, SFR_WE, SFR_WDATA, dst} = '0;
      repeat (5) @(negedge CLK);
      RST_N = 1'b1;
      chk(PM_ADDR, cafd_pkg::PC_RST);
      chk({ALU_FLAGS, WORK_REG}, {cafd_pkg::FLAGS_RST, cafd_pkg::WORK_RST});
      chk(PRODUCT_PAIR, cafd_pkg::PROD_RST);
      chk(INSN_EX, cafd_pkg::INSN_NOP);
      for (int i = 0; i < 72; i++) begin
         op = 4'(i % 12);
         if (op == 4'hB) begin
            op = 4'hC;
         end
         w = i < 12 ? 8'hFF : i < 24 ? 8'h7F : 8'(rnd());
         f = i < 24 ? 8'h01 : 8'(rnd());
         fl = 8'(rnd()) & 8'h0F;
         dst = (i < 24) || (rnd() % 2 == 1);
         drive(4'h0, 3'h2, 1'b1, w, 8'h00);
         drive(4'h0, 3'h3, 1'b1, fl, w);
         drive(op, 3'h2, 1'b0, 8'h00, f);
         e = model(op, w, f, fl);
         chk(SFR_RDATA, w);
         chk({DM_WE, DM_WDATA}, {!dst && op != 4'h0 && op != 4'hA, e[7:0]});
         drive(4'hB, 3'h0, 1'b0, 8'h00, 8'h00);
         chk({DM_WE, DM_WDATA}, {1'b1, DM_SRC_DATA});
         chk(ALU_FLAGS, e[15:8]);
         chk(WORK_REG, (dst && op != 4'h0 && op != 4'hA) ? e[7:0] : w);
         if (op == 4'hA) begin
            chk(PRODUCT_PAIR, 16'(w) * 16'(f));
         end
      end
      for (int k = 0; k < 2; k++) begin
         drive(4'h0, 3'h0, 1'b0, 8'h00, 8'h00);
         EX_BRANCH = k == 0;
         EX_MULTI = k == 1;
         EX_TARGET = 16'hFFFF;
         #1;
         chk(STALL, 1'b1);
         drive(4'h0, 3'h0, 1'b0, 8'h00, 8'h00);
         EX_BRANCH = 1'b0;
         EX_MULTI = 1'b0;
         #1;
         chk(INSN_EX, 16'h0000);
         chk(STALL, 1'b1);
         if (k == 0) begin
            chk(PM_ADDR, 16'hFFFF);
            chk(PM_EXT_SEL, EXEC_MODE[1]);
         end
         drive(4'h0, 3'h0, 1'b0, 8'h00, 8'h00);
         chk(STALL, 1'b0);
      end
      for (int m = 0; m < 4; m++) begin
         drive(4'h0, 3'h0, 1'b0, 8'h00, 8'h00);
         EXEC_MODE = 2'(m);
         #1;
         chk(PM_EXT_SEL, m == 3);
         chk(PROTECT_ACTIVE, m == 1 || (m == 0 && PROTECT_REQ));
      end
      drive(4'h0, 3'h4, 1'b1, 8'h5A, 8'h00);
      drive(4'h0, 3'h5, 1'b1, 8'hA5, 8'h00);
      drive(4'h0, 3'h5, 1'b0, 8'h00, 8'h00);
      chk(PRODUCT_PAIR, 16'hA55A);
      chk(SFR_RDATA, 8'hA5);
      summarize();
   end
endmodule
